//--- logic/stis_defines.svh
// What this block does
// - Self-test runs only after power-up; bus or device reset go straight to initialization.
// - A failing self-test step lights the error pattern and stops all initialization.
// - Selection on the bus gets no response while the self-test runs.
// - Steps run: hw reset, processor, firmware sum, buffer, memory, formatter, bus chip.
// - Each step starts only after the previous passed; the first failure stops there.
// - A hardware reset check failure clears only by power-up; bus reset is ignored.
// - Any other step failure clears by bus reset or by power-up.
// - Firmware check sums memory words and fails when the stored sum differs.
// - LEDs: 00 hw check, 01 cpu to memory, 10 formatter and bus chip, 11 pass.
// - After a failure the LEDs keep the pattern of the failing step group.
// - The reset-clear code shows before the self-test, the pass code after success.
// - Reset-clear code is both LEDs off; pass code is both LEDs on.
// - Self-test may last 10 seconds without answering selection; initiator waits.
// - Initialization runs on power-up, bus reset, or a device reset message.
// - Init first marks every unit busy, sets up the bus side, enables interrupts.
// - After that first step selections are answered, with BUSY until init ends.
// - Units without a drive are skipped; others load default parameters.
// - Start-unit goes to each drive only on power-up with spin-up enabled.
// - After drive setup the ready LED lights, then busy clears and commands run.
// - In idle the green LED blinks continuously.
// - The first command after initialization ends with CHECK and UNIT ATTENTION.
// - Media commands before a drive spins up end with CHECK and NOT READY.
// - Saved mode data loads on first media command after spin-up; defaults before.
//
// Purpose: offsets, field positions and timing counts of the self-test sequencer
// Assumes: 10 MHz controller clock
// Notes:   definitions only
`ifndef STIS_DEFINES_SVH
`define STIS_DEFINES_SVH
`define STIS_CLK_HZ      10000000
`define STIS_ST_MAX_S    10
`define STIS_BLINK_MS    500
`define STIS_NLUN        2
`define STIS_AW          5
`define STIS_REG_STEPRES 5'h00
`define STIS_REG_FWDATA  5'h04
`define STIS_REG_FWEND   5'h08
`define STIS_REG_STATUS  5'h0C
`define STIS_REG_SUM     5'h10
`define STIS_RES_PASS    0
`define STIS_RES_FAIL    1
`define STIS_LED_CLEAR   2'h0
`define STIS_LED_PASS    2'h3
`define STIS_LED_GRP_A   2'h1
`define STIS_LED_GRP_B   2'h2
`endif

//--- logic/stis_pkg.sv
// Purpose: types of the self-test sequencer
// Assumes: nothing
// Notes:   command and answer carriers for the initiator side
package stis_pkg;
    typedef enum logic [3:0] {
        ST_HWRST, ST_CPU, ST_FWSUM, ST_BUF, ST_DRAM, ST_FMT, ST_SCSI,
        ST_FAIL, IN_BUSY, IN_IFACE, IN_IRQ, IN_LUN, IN_READY, IN_IDLE
    } stis_state_t;
    typedef enum logic [1:0] {RS_GOOD, RS_BUSY, RS_CHECK} stis_status_t;
    typedef enum logic [1:0] {SK_NONE, SK_UNIT_ATTN, SK_NOT_READY} stis_sense_t;
    typedef struct packed {
        logic valid;
        logic lun;
        logic media;
        logic modeSense;
    } stis_cmd_t;
    typedef struct packed {
        logic         valid;
        stis_status_t status;
        stis_sense_t  sense;
        logic         loadSaved;
        logic         defaultMode;
    } stis_rsp_t;
endpackage

//--- logic/stis_sequencer.sv
// Purpose: power-up self-test and reset initialization sequencer
// Assumes: rst is the power-up reset; test engines report through registers
// Notes:   pins from outside pass two flip-flops; cmd comes from same-clock logic
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "stis_defines.svh"
module stis_sequencer import stis_pkg::*; #(
    parameter int unsigned ST_MAX_CYC = `STIS_ST_MAX_S * `STIS_CLK_HZ,
    parameter int unsigned BLINK_CYC  = `STIS_BLINK_MS * (`STIS_CLK_HZ / 1000)
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic [`STIS_AW-1:0]    avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   scsiRstPin,
    input  wire logic                   busDevRstMsg,
    input  wire logic                   selPin,
    output logic                        selAck,
    input  wire logic                   spinUpOffSw,
    input  wire logic [`STIS_NLUN-1:0]  drivePresent,
    input  wire logic [`STIS_NLUN-1:0]  driveSpunUp,
    output logic      [`STIS_NLUN-1:0]  lunBusy,
    output logic      [`STIS_NLUN-1:0]  startUnit,
    output logic      [`STIS_NLUN-1:0]  paramLoad,
    output logic                        scsiIfInit,
    output logic                        scsiIrqEn,
    output logic                        readyLed,
    output logic                        ledRed,
    output logic                        ledGreen,
    input  stis_cmd_t                   cmdIn,
    output stis_rsp_t                   rspOut
);
    localparam int NL = `STIS_NLUN;

    stis_state_t     stateReg;
    stis_state_t     failStepReg;
    logic            powerUpReg;
    logic            lunReg;
    logic [26:0]     tmoReg;
    logic [26:0]     blinkCntReg;
    logic            blinkReg;
    logic [15:0]     sumReg;
    logic            ackReg;
    logic [1:0]      ledReg;
    logic [NL-1:0]   spunSeenReg;
    logic [NL-1:0]   savedReg;
    logic            unitAttnReg;
    logic [1:0]      rstSync;
    logic            rstPrev;
    logic [1:0]      selSync;
    logic [1:0]      swSync;
    logic [NL-1:0]   presSync0;
    logic [NL-1:0]   presSync1;
    logic [NL-1:0]   spunSync0;
    logic [NL-1:0]   spunSync1;
    logic            busRstEdge;
    logic            resetTrig;
    logic            inTest;
    logic            wrStep;
    logic            wrEnd;
    logic            stepPass;
    logic            stepFail;
    logic            tmoHit;

    // Two-stage synchronisers for every pin; only stage two is read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rstSync   <= 2'h0;
            selSync   <= 2'h0;
            swSync    <= 2'h0;
            presSync0 <= '0;
            presSync1 <= '0;
            spunSync0 <= '0;
            spunSync1 <= '0;
            rstPrev   <= 1'b0;
        end else if (ce) begin
            rstSync   <= {rstSync[0], scsiRstPin};
            selSync   <= {selSync[0], selPin};
            swSync    <= {swSync[0], spinUpOffSw};
            presSync0 <= drivePresent;
            presSync1 <= presSync0;
            spunSync0 <= driveSpunUp;
            spunSync1 <= spunSync0;
            rstPrev   <= rstSync[1];
        end
    end

    // Bus reset acts on its rising edge so a long pulse restarts only once
    assign busRstEdge = rstSync[1] & ~rstPrev;
    assign resetTrig  = busRstEdge | busDevRstMsg;
    assign inTest     = (stateReg <= ST_SCSI);

    // Register decode; a write is taken on the cycle its acknowledge is given
    assign wrStep   = avs_write & ackReg & (avs_address == `STIS_REG_STEPRES);
    assign wrEnd    = avs_write & ackReg & (avs_address == `STIS_REG_FWEND);
    assign tmoHit   = (tmoReg == 27'(ST_MAX_CYC - 1));
    // Checksum step uses its own compare, all other steps the result register
    assign stepPass = (stateReg == ST_FWSUM) ? (wrEnd & (avs_writedata[15:0] == sumReg))
                    : (wrStep & avs_writedata[`STIS_RES_PASS] & ~avs_writedata[`STIS_RES_FAIL]);
    assign stepFail = tmoHit
                    | ((stateReg == ST_FWSUM) ? (wrEnd & (avs_writedata[15:0] != sumReg))
                    : (wrStep & avs_writedata[`STIS_RES_FAIL]));

    // Main sequence: power-up enters the tests, other triggers go straight to init
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg    <= ST_HWRST;
            failStepReg <= ST_HWRST;
            lunReg      <= 1'b0;
        end else if (ce) begin
            unique case (stateReg)
                ST_HWRST, ST_CPU, ST_FWSUM, ST_BUF, ST_DRAM, ST_FMT, ST_SCSI: begin
                    if (stepFail) begin
                        failStepReg <= stateReg;
                        stateReg    <= ST_FAIL;
                    end else if (stepPass) begin
                        stateReg <= (stateReg == ST_SCSI) ? IN_BUSY
                                  : stis_state_t'(stateReg + 4'h1);
                    end
                end
                ST_FAIL: begin
                    // A catastrophic failure waits for power-up only
                    if (busRstEdge && failStepReg != ST_HWRST) begin
                        stateReg <= IN_BUSY;
                    end
                end
                IN_BUSY:  stateReg <= IN_IFACE;
                IN_IFACE: stateReg <= IN_IRQ;
                IN_IRQ: begin
                    stateReg <= IN_LUN;
                    lunReg   <= 1'b0;
                end
                IN_LUN: begin
                    if (resetTrig) begin
                        stateReg <= IN_BUSY;
                    end else if (lunReg == 1'(NL - 1)) begin
                        stateReg <= IN_READY;
                    end else begin
                        lunReg <= lunReg + 1'b1;
                    end
                end
                IN_READY: stateReg <= resetTrig ? IN_BUSY : IN_IDLE;
                IN_IDLE:  if (resetTrig) stateReg <= IN_BUSY;
            endcase
        end
    end

    // Power-up marker decides about start-unit; cleared by a reset trigger after the self-test, and in the failure state by bus reset only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            powerUpReg <= 1'b1;
        end else if (ce && (resetTrig && !inTest && stateReg != ST_FAIL
                            || stateReg == ST_FAIL && busRstEdge)) begin
            powerUpReg <= 1'b0;
        end
    end

    // Self-test watchdog; a hung step counts as a failure of that step
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tmoReg <= 27'h0;
        end else if (ce) begin
            tmoReg <= inTest ? tmoReg + 27'h1 : 27'h0;
        end
    end

    // Running firmware sum, fed word by word over the register bus
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sumReg <= 16'h0;
        end else if (ce && ackReg && avs_write && stateReg == ST_FWSUM
                     && avs_address == `STIS_REG_FWDATA) begin
            sumReg <= sumReg + avs_writedata[15:0];
        end
    end

    // LED code per step group; held when the sequence stops on a failure
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ledReg <= `STIS_LED_CLEAR;
        end else if (ce) begin
            unique case (stateReg)
                ST_HWRST:                       ledReg <= `STIS_LED_CLEAR;
                ST_CPU, ST_FWSUM, ST_BUF, ST_DRAM: ledReg <= `STIS_LED_GRP_A;
                ST_FMT, ST_SCSI:                ledReg <= `STIS_LED_GRP_B;
                ST_FAIL:                        ledReg <= ledReg;
                default:                        ledReg <= `STIS_LED_PASS;
            endcase
        end
    end

    // Idle blink; a long period keeps the count well under its width
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            blinkCntReg <= 27'h0;
            blinkReg    <= 1'b0;
        end else if (ce) begin
            if (stateReg != IN_IDLE) begin
                blinkCntReg <= 27'h0;
                blinkReg    <= 1'b1;
            end else if (blinkCntReg == 27'(BLINK_CYC - 1)) begin
                blinkCntReg <= 27'h0;
                blinkReg    <= ~blinkReg;
            end else begin
                blinkCntReg <= blinkCntReg + 27'h1;
            end
        end
    end

    assign ledRed   = (stateReg == IN_IDLE) ? 1'b0 : ledReg[1];
    assign ledGreen = (stateReg == IN_IDLE) ? blinkReg : ledReg[0];

    // Per-unit init pulses, a registered copy of the spin-up state and the sticky saved-mode state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            startUnit   <= '0;
            paramLoad   <= '0;
            spunSeenReg <= '0;
            savedReg    <= '0;
        end else if (ce) begin
            startUnit <= '0;
            paramLoad <= '0;
            if (stateReg == IN_LUN && presSync1[lunReg]) begin
                paramLoad[lunReg] <= 1'b1;
                startUnit[lunReg] <= powerUpReg & ~swSync[1];
            end
            spunSeenReg <= spunSync1;
            if (stateReg == IN_BUSY) begin
                savedReg <= '0;
            end else if (cmdIn.valid && stateReg == IN_IDLE && !unitAttnReg
                         && cmdIn.media && spunSync1[cmdIn.lun]) begin
                savedReg[cmdIn.lun] <= 1'b1;
            end
        end
    end

    // Unit attention is armed as init finishes and spent by the first command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unitAttnReg <= 1'b0;
        end else if (ce) begin
            if (stateReg == IN_READY) begin
                unitAttnReg <= 1'b1;
            end else if (cmdIn.valid && stateReg == IN_IDLE) begin
                unitAttnReg <= 1'b0;
            end
        end
    end

    // Command answer, one cycle after the command; BUSY while init runs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rspOut <= '0;
        end else if (ce) begin
            rspOut <= '0;
            if (cmdIn.valid && !inTest && stateReg != ST_FAIL) begin
                rspOut.valid <= 1'b1;
                if (stateReg != IN_IDLE) begin
                    rspOut.status <= RS_BUSY;
                end else if (unitAttnReg) begin
                    rspOut.status <= RS_CHECK;
                    rspOut.sense  <= SK_UNIT_ATTN;
                end else if (cmdIn.media && !spunSync1[cmdIn.lun]) begin
                    rspOut.status <= RS_CHECK;
                    rspOut.sense  <= SK_NOT_READY;
                end else begin
                    rspOut.status      <= RS_GOOD;
                    rspOut.loadSaved   <= cmdIn.media & ~savedReg[cmdIn.lun];
                    rspOut.defaultMode <= cmdIn.modeSense & ~spunSync1[cmdIn.lun];
                end
            end
        end
    end

    // Bus side enable outputs and unit busy flags follow the init phase
    assign scsiIfInit = (stateReg == IN_IFACE);
    assign scsiIrqEn  = (stateReg > IN_IFACE) && (stateReg != ST_FAIL);
    assign readyLed   = (stateReg == IN_READY) || (stateReg == IN_IDLE);
    assign lunBusy    = (stateReg >= IN_BUSY && stateReg <= IN_READY) ? '1 : '0;
    // No answer to selection during test or after a failure
    assign selAck     = selSync[1] && stateReg >= IN_IRQ;

    // Avalon slave: one wait cycle, acknowledge on the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ackReg <= 1'b0;
        end else if (ce) begin
            ackReg <= (avs_read | avs_write) & ~ackReg;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ackReg;

    // Read data; unmapped and write-only words read as zero
    always_comb begin
        avs_readdata = 32'h0;
        unique case (avs_address)
            `STIS_REG_STATUS: avs_readdata = {20'h0, ledRed, ledGreen,
                                              failStepReg, stateReg, powerUpReg,
                                              readyLed};
            `STIS_REG_SUM:    avs_readdata = {16'h0, sumReg};
            default:          avs_readdata = 32'h0;
        endcase
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    step_order_a: assert property (ce && inTest && stepPass && !stepFail
        && stateReg != ST_SCSI |=> stateReg == $past(stateReg) + 4'h1)
        else $error("self-test step skipped");
    fail_stop_a: assert property (ce && inTest && stepFail |=> stateReg == ST_FAIL
        && failStepReg == $past(stateReg))
        else $error("failure did not stop the sequence");
    cat_hold_a: assert property (stateReg == ST_FAIL && failStepReg == ST_HWRST
        |=> stateReg == ST_FAIL)
        else $error("catastrophic failure left without power-up");
    fail_clear_a: assert property (ce && stateReg == ST_FAIL && failStepReg != ST_HWRST
        && busRstEdge |=> stateReg == IN_BUSY ##3 stateReg == IN_LUN)
        else $error("bus reset did not clear failure");
    no_select_a: assert property (inTest || stateReg == ST_FAIL |-> !selAck
        && !rspOut.valid || $past(stateReg) != stateReg)
        else $error("selection answered during self-test");
    led_fail_a: assert property (stateReg == ST_FAIL ##1 stateReg == ST_FAIL
        |-> $stable(ledRed) && $stable(ledGreen))
        else $error("failure LED code changed");
    led_grp_a: assert property (ce && stateReg == ST_FMT ##1 ce |=>
        !ledGreen && ledRed || stateReg == ST_FAIL)
        else $error("formatter LED code wrong");
    busy_rsp_a: assert property (ce && cmdIn.valid && stateReg inside {[IN_IRQ:IN_READY]}
        |=> rspOut.valid && rspOut.status == RS_BUSY)
        else $error("command not answered busy during init");
    attn_first_a: assert property (ce && cmdIn.valid && stateReg == IN_IDLE && unitAttnReg
        |=> rspOut.status == RS_CHECK && rspOut.sense == SK_UNIT_ATTN ##1 !unitAttnReg)
        else $error("first command missed unit attention");
    no_spin_a: assert property (!powerUpReg |-> startUnit == '0 || $past(powerUpReg))
        else $error("start unit sent after reset trigger");
endmodule  // stis_sequencer

//--- sim/stis_initiator.sv
// Purpose: initiator model that selects the block and issues commands
// Assumes: same clock as the block; one command outstanding
// Notes:   answer is sampled at the falling edge once it has settled
`timescale 1ns/100ps
module stis_initiator import stis_pkg::*; (
    input  wire logic clk_sys,
    input  stis_rsp_t rspOut,
    output logic      selPin,
    output stis_cmd_t cmdIn
);
    // Quiet bus at time zero
    initial begin
        selPin = 1'b0;
        cmdIn  = '0;
    end
    // Selection is held; a missing answer during self-test is not an error
    task automatic sel(input logic v);
        @(posedge clk_sys);
        selPin <= v;
    endtask
    // One command pulse; r.valid stays low when the block does not answer
    task automatic issue(input logic l, input logic m, input logic s, output stis_rsp_t r);
        @(posedge clk_sys);
        cmdIn <= '{1'b1, l, m, s};
        @(posedge clk_sys);
        cmdIn <= '0;
        @(negedge clk_sys);
        r = rspOut;
    endtask
endmodule // stis_initiator

//--- sim/stis_sequencer_tb.sv
// Purpose: self-checking bench of the self-test and init sequencer
// Assumes: short self-test watchdog and blink count for simulation
// Notes:   bus master waits for waitrequest low at a rising edge
`timescale 1ns/100ps
`include "stis_defines.svh"
module stis_sequencer_tb import stis_pkg::*; ;
    localparam int BLINK = 8;
    logic                clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [`STIS_AW-1:0] avs_address = '0;
    logic                avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0]         avs_writedata = '0, avs_readdata, rdv;
    logic                scsiRstPin = 1'b0, busDevRstMsg = 1'b0, selPin, selAck;
    logic                spinUpOffSw = 1'b0, scsiIfInit, scsiIrqEn, readyLed, ledRed, ledGreen;
    logic [1:0]          drivePresent = 2'b01, driveSpunUp = 2'b00, lunBusy;
    logic [1:0]          startUnit, paramLoad, suSeen, plSeen;
    logic                passSeen, ifSeen;
    int                  bad_count = 0, tests_run = 0;
    stis_cmd_t           cmdIn;
    stis_rsp_t           rspOut, rs;

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    stis_sequencer #(.ST_MAX_CYC(2000), .BLINK_CYC(BLINK)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .scsiRstPin(scsiRstPin), .busDevRstMsg(busDevRstMsg), .selPin(selPin),
        .selAck(selAck), .spinUpOffSw(spinUpOffSw), .drivePresent(drivePresent),
        .driveSpunUp(driveSpunUp), .lunBusy(lunBusy), .startUnit(startUnit),
        .paramLoad(paramLoad), .scsiIfInit(scsiIfInit), .scsiIrqEn(scsiIrqEn),
        .readyLed(readyLed), .ledRed(ledRed), .ledGreen(ledGreen), .cmdIn(cmdIn),
        .rspOut(rspOut));
    stis_initiator i_ini (.clk_sys(clk_sys), .rspOut(rspOut), .selPin(selPin), .cmdIn(cmdIn));

    // Pulses are short, so they are latched here while the init sequence runs
    always @(posedge clk_sys) begin
        suSeen <= suSeen | startUnit;
        plSeen <= plSeen | paramLoad;
        if (ledRed && ledGreen && lunBusy == 2'b11) passSeen <= 1'b1;
        if (scsiIfInit && lunBusy == 2'b11) ifSeen <= 1'b1;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One Avalon access; read data are taken at the edge that ends the wait
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) chk("waitrequest", 0, 1);
    endtask
    // Cleared off the edge so the latching process cannot write back stale flags
    task automatic clr();
        @(negedge clk_sys);
        suSeen   = '0;
        plSeen   = '0;
        passSeen = 1'b0;
        ifSeen   = 1'b0;
    endtask
    task automatic power();
        @(posedge clk_sys);
        rst <= 1'b1;
        waitc(16);
        rst <= 1'b0;
        waitc(3);
        chk("clearleds", `STIS_LED_CLEAR, {ledRed, ledGreen});
    endtask
    // Walks the steps in order, failing step f (7 means all pass)
    task automatic selftest(input int f);
        logic [1:0] led;
        clr();
        for (int s = 0; s < 7; s++) begin
            // LED code follows the step register one edge later
            waitc(2);
            led = (s == 0) ? `STIS_LED_CLEAR : (s < 5) ? `STIS_LED_GRP_A : `STIS_LED_GRP_B;
            chk("leds", led, {ledRed, ledGreen});
            bus(0, `STIS_REG_STATUS, 0);
            chk("step", s, rdv[5:2]);
            chk("selack", 0, selAck);
            if (s == 1) i_ini.issue(0, 0, 0, rs);
            if (s == 1) chk("testrsp", 0, rs.valid);
            if (s == 2) begin
                bus(1, `STIS_REG_FWDATA, 32'h0000_1234);
                bus(1, `STIS_REG_FWDATA, 32'h0000_F0F0);
                bus(0, `STIS_REG_SUM, 0);
                chk("sum", 32'h0000_0324, rdv);
                bus(1, `STIS_REG_FWEND, (f == 2) ? 32'h0000_0000 : 32'h0000_0324);
            end else bus(1, `STIS_REG_STEPRES, (s == f) ? 32'h2 : 32'h1);
            if (s == f) begin
                waitc(2);
                bus(0, `STIS_REG_STATUS, 0);
                chk("failstate", ST_FAIL, rdv[5:2]);
                chk("failstep", f, rdv[9:6]);
                chk("failleds", led, {ledRed, ledGreen});
                chk("failsel", 0, selAck);
                return;
            end
        end
    endtask
    // Waits for idle and judges what the init sequence did on the way
    task automatic idle(input logic [1:0] su, input logic [1:0] pl);
        int n;
        logic g;
        n = 0;
        do begin
            bus(0, `STIS_REG_STATUS, 0);
            n++;
        end while (rdv[5:2] !== IN_IDLE && n < 20);
        chk("idle", IN_IDLE, rdv[5:2]);
        chk("ready", 1, readyLed);
        chk("busy", 0, lunBusy);
        chk("spinup", su, suSeen);
        chk("params", pl, plSeen);
        chk("passcode", 1, passSeen);
        chk("ifinit", 1, ifSeen);
        chk("irqen", 1, scsiIrqEn);
        chk("selack", 1, selAck);
        chk("red", 0, ledRed);
        n = 0;
        g = ledGreen;
        repeat (4 * BLINK) begin
            @(posedge clk_sys);
            if (ledGreen !== g) n++;
            g = ledGreen;
        end
        chk("blinks", 4, n);
    endtask
    // Reset trigger without self-test: 0 bus reset pin, 1 device reset message
    task automatic trig(input int k, input logic [1:0] pl);
        clr();
        @(posedge clk_sys);
        if (k == 0) scsiRstPin <= 1'b1;
        else busDevRstMsg <= 1'b1;
        @(posedge clk_sys);
        busDevRstMsg <= 1'b0;
        waitc(4);
        scsiRstPin <= 1'b0;
        idle(2'b00, pl);
    endtask
    // Command answers after init, before and after spin-up of unit 0
    task automatic cmds();
        i_ini.issue(0, 0, 0, rs);
        chk("first", {1'b1, RS_CHECK, SK_UNIT_ATTN, 2'b00}, rs);
        i_ini.issue(0, 1, 0, rs);
        chk("notready", {1'b1, RS_CHECK, SK_NOT_READY, 2'b00}, rs);
        i_ini.issue(0, 0, 1, rs);
        chk("defmode", {1'b1, RS_GOOD, SK_NONE, 2'b01}, rs);
        @(posedge clk_sys);
        driveSpunUp <= 2'b01;
        waitc(4);
        i_ini.issue(0, 1, 0, rs);
        chk("saved", {1'b1, RS_GOOD, SK_NONE, 2'b10}, rs);
        i_ini.issue(0, 1, 0, rs);
        chk("again", {1'b1, RS_GOOD, SK_NONE, 2'b00}, rs);
    endtask
    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        power();
        i_ini.sel(1'b1);
        selftest(7);
        idle(2'b01, 2'b01);
        cmds();
        trig(0, 2'b01);
        trig(1, 2'b01);
        power();
        selftest(5);
        trig(0, 2'b01);
        power();
        selftest(0);
        scsiRstPin <= 1'b1;
        waitc(8);
        bus(0, `STIS_REG_STATUS, 0);
        chk("hwfail", ST_FAIL, rdv[5:2]);
        scsiRstPin <= 1'b0;
        power();
        selftest(2);
        spinUpOffSw  <= 1'b1;
        drivePresent <= 2'b11;
        driveSpunUp  <= 2'b00;
        power();
        selftest(7);
        idle(2'b00, 2'b11);
        summarize();
    end
    // Hang guard, well beyond the expected run length
    initial begin
        #(100 * 40000);
        chk("watchdog", 0, 1);
        summarize();
    end
endmodule // stis_sequencer_tb
